// >>> hw/tafq_ctrl.sv
// Conversion sequencing, alert qualification and APB register file
`timescale 1ns/1ps
`default_nettype none
`include "tafq_params.svh"
// Contract
// [RULE1] Alert only after queue-length consecutive over-limit results
// [RULE2] Config bits 4:3 select fault queue length
// [RULE3] Same queue length applies below hysteresis
// [RULE4] Config bits 6:5 select 9 to 12 bit resolution
// [RULE5] Conversion lasts 30/60/120/240 ms per resolution
// [RULE6] Power-on reset restores all register defaults
// [RULE7] Defaults: temp 0, limit a000, hysteresis 9600
// [RULE8] Zero config: continuous, comparator, active-low, queue one
// [RULE9] Wait 2 ms before first conversion
// [RULE10] Temperature reads zero until first conversion ends
// [RULE11] Host uses active-low polarity when wire-ORed
// [RULE12] Config bit 1 mode, bit 2 polarity
// [RULE13] Comparator alert holds until below hysteresis
// [RULE14] Interrupt alert cleared by any register read
// [RULE15] Shutdown stops conversions, clears interrupt alert
// [RULE16] Queue codes 00/01/10/11 mean 1/2/4/6
// [RULE17] Queue run restarts on miss or config rewrite; code restarts only on a config write that changes bits 4:1
module tafq_ctrl
    import tafq_pkg::*;
#(
    parameter int PorCycles = (`TAFQ_POR_DELAY_US * (`TAFQ_CLK_HZ / 1000000)),
    parameter int ConvUnitCycles = (`TAFQ_CONV9_MS * (`TAFQ_CLK_HZ / 1000))
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] adcSample,
    output logic alertOut,
    output logic alertOe,
    output logic irq
);
    // Conversion length is the 9-bit time doubled per extra resolution bit
    localparam int Conv10Cycles = ConvUnitCycles * (`TAFQ_CONV10_MS / `TAFQ_CONV9_MS);
    localparam int Conv11Cycles = ConvUnitCycles * (`TAFQ_CONV11_MS / `TAFQ_CONV9_MS);
    localparam int Conv12Cycles = ConvUnitCycles * (`TAFQ_CONV12_MS / `TAFQ_CONV9_MS);

    typedef struct packed {
        tafq_phase_t phase;
        logic [23:0] timer;
        logic [15:0] temp;
        logic [15:0] limit;
        logic [15:0] hyst;
        logic [7:0] ptr;
        logic [7:0] cfg;
        logic [2:0] status;
        logic [2:0] mask;
        logic alertActive;
        logic convDone;
        logic restart;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic alertPin;
        logic alertEn;
        logic irq;
    } tafq_ctrl_state_t;

    tafq_ctrl_state_t st_r;
    tafq_ctrl_state_t st_nxt;

    // Sample bus is asynchronous to ref_clk: two flops before any use
    logic [15:0] sampleMeta_r;
    logic [15:0] sampleSync_r;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sampleMeta_r <= 16'h0000;
            sampleSync_r <= 16'h0000;
        end
        else if (clkEn)
        begin
            sampleMeta_r <= adcSample;
            sampleSync_r <= sampleMeta_r;
        end
    end

    // Conversion time for a resolution code
    function automatic logic [23:0] convCycles(input logic [1:0] res);
        case (res)
            2'h0: convCycles = 24'(ConvUnitCycles);
            2'h1: convCycles = 24'(Conv10Cycles);
            2'h2: convCycles = 24'(Conv11Cycles);
            default: convCycles = 24'(Conv12Cycles);
        endcase
    endfunction

    // Keep only the bits the selected resolution resolves
    function automatic logic [15:0] quantize(input logic [15:0] s, input logic [1:0] res);
        case (res)
            2'h0: quantize = s & 16'hff80;
            2'h1: quantize = s & 16'hffc0;
            2'h2: quantize = s & 16'hffe0;
            default: quantize = s & 16'hfff0;
        endcase
    endfunction

    logic hotState;
    logic fireHot;
    logic fireCool;

    tafq_fault_queue u_queue (
        .ref_clk(ref_clk),
        .rst(rst),
        .clkEn(clkEn),
        .restart(st_r.restart),
        .convDone(st_r.convDone),
        .sample(st_r.temp),
        .limitHigh(st_r.limit),
        .limitLow(st_r.hyst),
        .queueSel(st_r.cfg[`TAFQ_CFG_FQ_HI:`TAFQ_CFG_FQ_LO]), // see [RULE2] see [RULE16]
        .hotState(hotState),
        .fireHot(fireHot),
        .fireCool(fireCool)
    );

    logic access;
    logic rdAcc;
    logic wrAcc;
    logic shutdown;
    logic intMode;
    assign access = psel & penable & ~st_r.ready;
    assign rdAcc = access & ~pwrite;
    assign wrAcc = access & pwrite;
    assign shutdown = st_r.cfg[`TAFQ_CFG_SHDN];
    assign intMode = st_r.cfg[`TAFQ_CFG_INTMODE]; // see [RULE12]

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.convDone = 1'b0;
        st_nxt.restart = 1'b0;
        st_nxt.ready = 1'b0;
        st_nxt.err = 1'b0;
        st_nxt.rdata = 32'h00000000;

        // Sequencer: power-up wait, then conversions unless shut down
        case (st_r.phase)
            TAFQ_WAIT_POR:
            begin
                if (st_r.timer >= 24'(PorCycles - 1)) // see [RULE9]
                begin
                    st_nxt.phase = TAFQ_CONVERT;
                    st_nxt.timer = 24'h000000;
                end
                else
                    st_nxt.timer = st_r.timer + 24'h000001;
            end
            TAFQ_IDLE:
            begin
                st_nxt.timer = 24'h000000;
                if (!shutdown || st_r.cfg[`TAFQ_CFG_ONESHOT])
                    st_nxt.phase = TAFQ_CONVERT;
            end
            TAFQ_CONVERT:
            begin
                if (st_r.timer >= convCycles(st_r.cfg[`TAFQ_CFG_RES_HI:`TAFQ_CFG_RES_LO]) - 24'h000001) // see [RULE5]
                begin
                    // First valid result lands here only after a full period
                    st_nxt.temp = quantize(sampleSync_r, st_r.cfg[`TAFQ_CFG_RES_HI:`TAFQ_CFG_RES_LO]); // see [RULE4] see [RULE10]
                    st_nxt.convDone = 1'b1;
                    st_nxt.timer = 24'h000000;
                    st_nxt.status[`TAFQ_ST_CONV] = 1'b1;
                    st_nxt.cfg[`TAFQ_CFG_ONESHOT] = 1'b0;
                    if (shutdown)
                        st_nxt.phase = TAFQ_IDLE; // see [RULE15]
                end
                else if (shutdown && !st_r.cfg[`TAFQ_CFG_ONESHOT])
                    st_nxt.phase = TAFQ_IDLE; // see [RULE15]
                else
                    st_nxt.timer = st_r.timer + 24'h000001;
            end
            default:
                st_nxt.phase = TAFQ_WAIT_POR;
        endcase

        // Register access: one wait state, answer in the following cycle
        if (access)
        begin
            st_nxt.ready = 1'b1;
            if (paddr == `TAFQ_ADDR_TEMP)
            begin
                st_nxt.rdata = {16'h0000, st_r.temp};
            end
            else if (paddr == `TAFQ_ADDR_CFG)
            begin
                st_nxt.rdata = {24'h000000, st_r.cfg};
                if (pwrite)
                begin
                    st_nxt.cfg = pwdata[7:0];
                    // One-shot only honoured from shutdown
                    if (!st_r.cfg[`TAFQ_CFG_SHDN])
                        st_nxt.cfg[`TAFQ_CFG_ONESHOT] = 1'b0;
                    if (pwdata[`TAFQ_CFG_FQ_HI:`TAFQ_CFG_INTMODE] != st_r.cfg[`TAFQ_CFG_FQ_HI:`TAFQ_CFG_INTMODE])
                        st_nxt.restart = 1'b1; // see [RULE17]
                end
            end
            else if (paddr == `TAFQ_ADDR_HYST)
            begin
                st_nxt.rdata = {16'h0000, st_r.hyst};
                if (pwrite)
                    st_nxt.hyst = pwdata[15:0] & `TAFQ_LIMIT_MASK;
            end
            else if (paddr == `TAFQ_ADDR_LIMIT)
            begin
                st_nxt.rdata = {16'h0000, st_r.limit};
                if (pwrite)
                    st_nxt.limit = pwdata[15:0] & `TAFQ_LIMIT_MASK;
            end
            else if (paddr == `TAFQ_ADDR_PTR)
            begin
                st_nxt.rdata = {24'h000000, st_r.ptr};
                if (pwrite)
                    st_nxt.ptr = pwdata[7:0];
            end
            else if (paddr == `TAFQ_ADDR_STAT)
            begin
                st_nxt.rdata = {29'h00000000, st_r.status};
                if (!pwrite)
                    st_nxt.status = 3'h0;
            end
            else if (paddr == `TAFQ_ADDR_MASK)
            begin
                st_nxt.rdata = {29'h00000000, st_r.mask};
                if (pwrite)
                    st_nxt.mask = pwdata[2:0];
            end
            else
                st_nxt.err = 1'b1;
        end

        // Alert qualification per mode
        if (intMode)
        begin
            if (rdAcc)
                st_nxt.alertActive = 1'b0; // see [RULE14]
            if (wrAcc && paddr == `TAFQ_ADDR_CFG && pwdata[`TAFQ_CFG_SHDN])
                st_nxt.alertActive = 1'b0; // see [RULE15]
            // A fresh event beats a same-cycle acknowledge
            if (fireHot || fireCool)
                st_nxt.alertActive = 1'b1; // see [RULE1] see [RULE3]
        end
        else
        begin
            st_nxt.alertActive = hotState; // see [RULE13]
        end

        // Sticky events; set beats the clearing read
        if (fireHot)
            st_nxt.status[`TAFQ_ST_ALERT] = 1'b1;
        if (fireCool)
            st_nxt.status[`TAFQ_ST_CLEAR] = 1'b1;
        if (st_nxt.convDone)
            st_nxt.status[`TAFQ_ST_CONV] = 1'b1;

        // Open-drain style pin when active-low: drive only when the level is low; active-high always drives
        st_nxt.alertPin = st_nxt.alertActive ~^ st_nxt.cfg[`TAFQ_CFG_POL]; // see [RULE12]
        st_nxt.alertEn = ~st_nxt.alertPin | st_nxt.cfg[`TAFQ_CFG_POL];
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    // Async reset stands in for the power-on reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.phase <= TAFQ_WAIT_POR;
            st_r.temp <= `TAFQ_RST_TEMP; // see [RULE6] see [RULE7]
            st_r.limit <= `TAFQ_RST_LIMIT;
            st_r.hyst <= `TAFQ_RST_HYST;
            st_r.ptr <= `TAFQ_RST_PTR;
            st_r.cfg <= `TAFQ_RST_CFG; // see [RULE8]
            st_r.alertPin <= 1'b1;
            st_r.alertEn <= 1'b0;
        end
        else if (clkEn)
            st_r <= st_nxt;
    end

    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.err;
    assign alertOut = st_r.alertPin;
    assign alertOe = st_r.alertEn;
    assign irq = st_r.irq;
endmodule // tafq_ctrl
`default_nettype wire

// >>> hw/tafq_fault_queue.sv
// Consecutive-conversion fault queue for both crossing directions
`timescale 1ns/1ps
`default_nettype none
`include "tafq_params.svh"
module tafq_fault_queue
    import tafq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic restart,
    input wire logic convDone,
    input wire logic [15:0] sample,
    input wire logic [15:0] limitHigh,
    input wire logic [15:0] limitLow,
    input wire logic [1:0] queueSel,
    output logic hotState,
    output logic fireHot,
    output logic fireCool
);
    tafq_queue_t state_r;
    tafq_queue_t state_nxt;

    // Map field code to required run length
    function automatic logic [2:0] queueLen(input logic [1:0] sel);
        case (sel)
            2'h0: queueLen = 3'h1;
            2'h1: queueLen = 3'h2;
            2'h2: queueLen = 3'h4;
            default: queueLen = 3'h6;
        endcase
    endfunction

    // Signed compare on the nine significant bits only
    logic over;
    logic under;
    assign over = $signed(sample & `TAFQ_LIMIT_MASK) > $signed(limitHigh & `TAFQ_LIMIT_MASK);
    assign under = $signed(sample & `TAFQ_LIMIT_MASK) < $signed(limitLow & `TAFQ_LIMIT_MASK);

    // Count runs of the pending crossing; a miss restarts the run
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.fire = 1'b0;
        state_nxt.clear = 1'b0;
        if (restart)
        begin
            state_nxt.count = 3'h0; // see [RULE17]
        end
        else if (convDone)
        begin
            if (state_r.hot ? under : over)
            begin
                if (state_r.count + 3'h1 >= queueLen(queueSel)) // see [RULE1] see [RULE3]
                begin
                    state_nxt.count = 3'h0;
                    state_nxt.hot = ~state_r.hot;
                    state_nxt.fire = ~state_r.hot;
                    state_nxt.clear = state_r.hot;
                end
                else
                begin
                    state_nxt.count = state_r.count + 3'h1;
                end
            end
            else
            begin
                state_nxt.count = 3'h0; // see [RULE17]
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            state_r <= '0;
        else if (clkEn)
            state_r <= state_nxt;
    end

    assign hotState = state_r.hot;
    assign fireHot = state_r.fire;
    assign fireCool = state_r.clear;
endmodule // tafq_fault_queue
`default_nettype wire

// >>> hw/tafq_params.svh
// Constants for the temperature alert fault queue controller
`ifndef TAFQ_PARAMS_SVH
`define TAFQ_PARAMS_SVH
`define TAFQ_CLK_HZ 50000000
`define TAFQ_POR_DELAY_US 2000
`define TAFQ_CONV9_MS 30
`define TAFQ_CONV10_MS 60
`define TAFQ_CONV11_MS 120
`define TAFQ_CONV12_MS 240
`define TAFQ_ADDR_TEMP 12'h000
`define TAFQ_ADDR_CFG 12'h004
`define TAFQ_ADDR_HYST 12'h008
`define TAFQ_ADDR_LIMIT 12'h00c
`define TAFQ_ADDR_PTR 12'h010
`define TAFQ_ADDR_STAT 12'h014
`define TAFQ_ADDR_MASK 12'h018
`define TAFQ_RST_TEMP 16'h0000
`define TAFQ_RST_LIMIT 16'ha000
`define TAFQ_RST_HYST 16'h9600
`define TAFQ_RST_PTR 8'h00
`define TAFQ_RST_CFG 8'h00
`define TAFQ_CFG_SHDN 0
`define TAFQ_CFG_INTMODE 1
`define TAFQ_CFG_POL 2
`define TAFQ_CFG_FQ_LO 3
`define TAFQ_CFG_FQ_HI 4
`define TAFQ_CFG_RES_LO 5
`define TAFQ_CFG_RES_HI 6
`define TAFQ_CFG_ONESHOT 7
`define TAFQ_LIMIT_MASK 16'hff80
`define TAFQ_ST_CONV 0
`define TAFQ_ST_ALERT 1
`define TAFQ_ST_CLEAR 2
`endif

// >>> hw/tafq_pkg.sv
// Types for the temperature alert fault queue controller
`default_nettype none
package tafq_pkg;
    typedef enum logic [1:0] {TAFQ_WAIT_POR, TAFQ_IDLE, TAFQ_CONVERT} tafq_phase_t;
    typedef struct packed {
        logic [2:0] count;
        logic hot;
        logic fire;
        logic clear;
    } tafq_queue_t;
endpackage
`default_nettype wire

// >>> test/tafq_ctrl_sva.sv
// Concurrent checks on the ports of the alert controller
`timescale 1ns/1ps
`default_nettype none
module tafq_ctrl_sva
#(
    parameter int PorCycles = 20,
    parameter int ConvUnitCycles = 10
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] adcSample,
    input wire logic alertOut,
    input wire logic alertOe,
    input wire logic irq
);
    logic cfgWr;
    logic rdDone;
    logic [7:0] cfgR;
    logic [15:0] adcPrev;
    int upCnt, cfgCnt, adcCnt, minRun;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Shadow config and run lengths; bounds stay lower limits since sync delay only adds
    assign cfgWr = psel && penable && pready && pwrite && paddr == 12'h004;
    assign rdDone = psel && penable && pready && !pwrite;
    assign minRun = ConvUnitCycles * ((cfgR[4:3] == 2'b11) ? 5 : (cfgR[4:3] == 2'b10) ? 3 :
        int'(cfgR[3]));
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cfgR <= 8'h00;
            adcPrev <= 16'h0000;
            upCnt <= 0;
            cfgCnt <= 0;
            adcCnt <= 0;
        end
        else
        begin
            upCnt <= upCnt + 1;
            cfgCnt <= cfgWr ? 0 : cfgCnt + 1;
            adcPrev <= adcSample;
            adcCnt <= (adcSample != adcPrev) ? 0 : adcCnt + 1;
            if (cfgWr)
                cfgR <= pwdata[7:0];
        end
    end
    a_por_quiet: assert property (upCnt < PorCycles + ConvUnitCycles |-> !alertOe && !irq)
        else $error("alert or irq before first conversion");
    a_temp_zero: assert property (psel && penable && !pready && !pwrite && paddr == 12'h000
        && upCnt < PorCycles + ConvUnitCycles |=> prdata == 32'h0)
        else $error("temperature nonzero before first conversion");
    a_ready_next: assert property (psel && penable && !pready && clkEn |=> pready ##1 !pready)
        else $error("pready not a one-cycle answer");
    a_hot_queue: assert property ($rose(alertOe) && !cfgR[1] && !cfgR[2] |-> cfgCnt >= minRun)
        else $error("alert asserted before fault queue filled");
    a_cool_queue: assert property ($fell(alertOe) && !cfgR[1] && !cfgR[2] |-> adcCnt >= minRun)
        else $error("alert released before fault queue filled");
    a_oe_low: assert property (alertOe && !cfgR[2] && !$past(cfgR[2]) |-> !alertOut)
        else $error("active-low pin driven high");
    a_intr_read: assert property (cfgR[1] && rdDone |-> ##[1:2] !alertOe)
        else $error("interrupt alert survives a read");
    a_shdn_clear: assert property (cfgWr && pwdata[1:0] == 2'b11 |-> ##[1:2] !alertOe)
        else $error("shutdown left interrupt alert active");
    a_irq_clear: assert property (rdDone && paddr == 12'h014 |-> ##[1:2] !irq)
        else $error("irq stays after status read");
endmodule // tafq_ctrl_sva
bind tafq_ctrl tafq_ctrl_sva #(.PorCycles(PorCycles), .ConvUnitCycles(ConvUnitCycles)) u_sva (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adcSample(adcSample), .alertOut(alertOut), .alertOe(alertOe),
    .irq(irq));
`default_nettype wire

// >>> test/tafq_ctrl_tb.sv
// Scenario bench for the alert controller with an APB master
`timescale 1ns/1ps
`default_nettype none
module tafq_ctrl_tb;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, alertOut, alertOe, irq;
    logic alertWire, rdErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdq;
    logic [15:0] adcSample;
    int n_errors = 0;
    int n_tests = 0;
    int n;
    // Short delays keep the run brief; expectations scale from these
    tafq_ctrl #(.PorCycles(20), .ConvUnitCycles(10)) dut (.ref_clk(ref_clk), .rst(rst),
        .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adcSample(adcSample), .alertOut(alertOut), .alertOe(alertOe), .irq(irq));
    tafq_host_model host (.alertOut(alertOut), .alertOe(alertOe), .alertWire(alertWire));
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task stop_test;
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask
    // One transfer; an idle edge after release avoids double assignment back to back
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rdq = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        if (k >= 20)
        begin
            n_errors++;
            stop_test;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdq, exp);
    endtask
    task automatic waitFor(input logic useIrq, input logic lvl, output int cnt);
        cnt = 0;
        while ((useIrq ? irq : alertWire) !== lvl && cnt < 400)
        begin
            @(posedge ref_clk);
            cnt++;
        end
        if (cnt >= 400)
        begin
            n_errors++;
            stop_test;
        end
    endtask
    task doReset;
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
    endtask
    task tDefaults;
        rd(12'h000, 32'h0);
        rd(12'h00c, 32'ha000);
        rd(12'h008, 32'h9600);
        rd(12'h010, 32'h0);
        rd(12'h004, 32'h0);
        apb(1'b0, 12'h01c, 32'h0);
        check(32'(rdErr), 32'h1);
        check(32'(alertWire), 32'h1);
    endtask
    // Queue of six: both directions need six whole conversions; between limits it holds
    task tQueue;
        // Default limits are negative in two's complement, so any warm sample
        // would trip them; program positive limits before the first conversion
        apb(1'b1, 12'h00c, 32'h5000);
        apb(1'b1, 12'h008, 32'h4b00);
        apb(1'b1, 12'h004, 32'h18);
        adcSample <= 16'h5100;
        waitFor(1'b0, 1'b0, n);
        check(32'(n >= 52 && n <= 80), 32'h1);
        adcSample <= 16'h4e00;
        repeat (80) @(posedge ref_clk);
        check(32'(alertWire), 32'h0);
        adcSample <= 16'h4000;
        waitFor(1'b0, 1'b1, n);
        check(32'(n >= 52 && n <= 80), 32'h1);
    endtask
    // Period between conversion events and result quantisation per resolution
    task tRes;
        adcSample <= 16'h4123;
        apb(1'b1, 12'h018, 32'h1);
        for (int r = 0; r < 4; r++)
        begin
            apb(1'b1, 12'h004, 32'(r << 5));
            waitFor(1'b1, 1'b1, n);
            apb(1'b0, 12'h014, 32'h0);
            waitFor(1'b1, 1'b1, n);
            rd(12'h014, 32'h1);
            waitFor(1'b1, 1'b1, n);
            check(32'(n + 4 >= (10 << r) - 1 && n + 4 <= (10 << r) + 1), 32'h1);
            rd(12'h000, 32'(16'h4123 & ~(16'h007f >> r)));
        end
    endtask
    task tIntr;
        apb(1'b1, 12'h018, 32'h2);
        apb(1'b1, 12'h004, 32'h2);
        adcSample <= 16'h5100;
        waitFor(1'b0, 1'b0, n);
        repeat (2) @(posedge ref_clk);
        check(32'(irq), 32'h1);
        rd(12'h004, 32'h2);
        check(32'(alertWire), 32'h1);
        apb(1'b0, 12'h014, 32'h0);
        check(rdq & 32'h2, 32'h2);
        adcSample <= 16'h4000;
        waitFor(1'b0, 1'b0, n);
        apb(1'b1, 12'h004, 32'h3);
        check(32'(alertWire), 32'h1);
        apb(1'b0, 12'h014, 32'h0);
        repeat (40) @(posedge ref_clk);
        apb(1'b0, 12'h014, 32'h0);
        check(rdq & 32'h1, 32'h0);
    endtask
    task tPor;
        apb(1'b1, 12'h00c, 32'h1234);
        rd(12'h00c, 32'h1200);
        doReset;
        rd(12'h00c, 32'ha000);
        rd(12'h004, 32'h0);
    endtask
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        adcSample = 16'h4000;
        doReset;
        tDefaults;
        tQueue;
        tRes;
        tIntr;
        tPor;
        stop_test;
    end
endmodule // tafq_ctrl_tb
`default_nettype wire

// >>> test/tafq_host_model.sv
// Host-side model of the open-drain alert line with its pull-up
`timescale 1ns/1ps
`default_nettype none
module tafq_host_model
(
    input wire logic alertOut,
    input wire logic alertOe,
    output logic alertWire
);
    // Released line rises to the pull-up; active-low keeps the wire-OR usable
    assign alertWire = alertOe ? alertOut : 1'b1;
endmodule // tafq_host_model
`default_nettype wire
